// ===== rtl/pmx_pad_select.sv
// Summary of operation
// - Four 32-bit banks of eight R/W 4-bit fields, all zero after reset.
// - Bank 14 bits 31-8: rt-unit-0 in, video in, host data, parallel data.
// - Bank 14 clock pads: rt-unit-1/dbl clock in, clock, strobe, rt out, gpio.
// - Bank 15 bits 31-8: inputs, host data, parallel data, rt-unit-0 out.
// - Bank 15 bits 7-0: no code 8h; codes 5h-Fh reserved.
// - Bank 16 bits 31-8: rt in, video out, lcd, parallel ext, gpio 7.
// - Bank 16 bits 7-4: rt in, video in, host, parallel, gpio 6 bit 5.
// - Bank 16 bits 3-0: code 8h is a rt-unit-0 output bit.
// - Output driver enabled only for output or bidirectional selections.
// - Bank 17: boot strap in, video out, lcd, parallel ext, gpio 7.
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`include "pmx_cfg.svh"

module pmx_pad_select (
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire pmx_pkg::pmx_avl_req_s  avl_req,
    output logic                        avl_waitrequest,
    output logic [`PMX_DATA_W-1:0]      avl_readdata,
    input  wire pmx_pkg::pmx_fn_s       fn_out,
    input  wire pmx_pkg::pmx_fn_s       fn_oe,
    output pmx_pkg::pmx_fn_s            fn_in,
    input  wire logic [`PMX_NPAD-1:0]   pad_i,
    output logic [`PMX_NPAD-1:0]        pad_o,
    output logic [`PMX_NPAD-1:0]        pad_oe
);
    import pmx_pkg::*;

    // ********************************************************
    // Kind of function per bank, field and code
    // ********************************************************
    function automatic pmx_kind_e pmx_kind(
        input logic [1:0] r,
        input logic [2:0] n,
        input logic [3:0] c
    );
        pmx_kind_e k;
        logic      lo;
        k  = PMX_K_NONE;
        lo = (n <= `PMX_NIB_LO1);
        case (c)
            `PMX_CODE_0: k = PMX_K_IN;
            `PMX_CODE_1: begin
                if (r == `PMX_REG17 || (r == `PMX_REG16 && !lo)) begin
                    k = PMX_K_OUT;
                end else begin
                    k = PMX_K_IN;
                end
            end
            `PMX_CODE_2: begin
                if (r == `PMX_REG14 && lo) begin
                    k = PMX_K_IN;
                end else begin
                    k = PMX_K_IO;
                end
            end
            `PMX_CODE_4: begin
                if (r == `PMX_REG14 && lo) begin
                    k = PMX_K_OUT;
                end else begin
                    k = PMX_K_IO;
                end
            end
            `PMX_CODE_8: begin
                case (r)
                    `PMX_REG14: k = lo ? PMX_K_IO : PMX_K_NONE;
                    `PMX_REG15: k = lo ? PMX_K_NONE : PMX_K_OUT;
                    `PMX_REG16: k = (n == 3'h0) ? PMX_K_OUT
                                                : PMX_K_IO;
                    default:    k = PMX_K_IO;
                endcase
            end
            default: k = PMX_K_NONE;
        endcase
        return k;
    endfunction : pmx_kind

    // ********************************************************
    // Registers and synchroniser
    // ********************************************************
    pmx_bank_t                 sel_q;
    logic                      wait_q;
    logic [`PMX_DATA_W-1:0]    rdata_q;
    logic [`PMX_NPAD-1:0]      sync1_q;
    logic [`PMX_NPAD-1:0]      sync2_q;
    logic [`PMX_NPAD-1:0]      pad_o_q;
    logic [`PMX_NPAD-1:0]      pad_oe_q;
    pmx_fn_s                   fn_in_q;
    logic [`PMX_NPAD-1:0]      pad_o_d;
    logic [`PMX_NPAD-1:0]      pad_oe_d;
    pmx_fn_s                   fn_in_d;
    logic                      req;
    logic                      take;
    logic                      hit;
    logic [1:0]                idx;
    logic [`PMX_DATA_W-1:0]    bmask;

    assign req  = avl_req.read | avl_req.write;
    assign take = req & ~wait_q;
    assign hit  = (avl_req.address[1:0] == 2'h0)
               && (avl_req.address <= `PMX_OFS_BANK17);
    assign idx  = avl_req.address[3:2];

    always_comb begin
        for (int b = 0; b < `PMX_BE_W; b++) begin
            bmask[b*8 +: 8] = {8{avl_req.byteenable[b]}};
        end
    end

    // ********************************************************
    // Avalon slave: one wait cycle, then accept
    // ********************************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wait_q <= 1'b1;
        end else if (req && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_q <= `PMX_RD_UNMAPPED;
        end else if (avl_req.read && wait_q) begin
            rdata_q <= hit ? sel_q[idx] : `PMX_RD_UNMAPPED;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int r = 0; r < `PMX_NREG; r++) begin
                sel_q[r] <= `PMX_RST_BANK;
            end
        end else if (take && avl_req.write && hit) begin
            sel_q[idx] <= (sel_q[idx] & ~bmask)
                        | (avl_req.writedata & bmask);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pad_i;
            sync2_q <= sync1_q;
        end
    end

    // ********************************************************
    // Per-pad routing
    // ********************************************************
    for (genvar p = 0; p < `PMX_NPAD; p++) begin : g_pad
        logic [3:0] code;
        pmx_kind_e  kind;
        logic       drv;
        logic       rcv;
        logic       fo;
        logic       foe;
        assign code = sel_q[p / `PMX_FIELDS][(p % `PMX_FIELDS)
                      * `PMX_FIELD_W +: `PMX_FIELD_W];
        assign kind = pmx_kind(2'(p / `PMX_FIELDS),
                               3'(p % `PMX_FIELDS), code);
        assign drv  = (kind == PMX_K_OUT) || (kind == PMX_K_IO);
        assign rcv  = (kind == PMX_K_IN) || (kind == PMX_K_IO);
        always_comb begin
            case (code)
                `PMX_CODE_1: begin
                    fo  = fn_out.c1[p];
                    foe = fn_oe.c1[p];
                end
                `PMX_CODE_2: begin
                    fo  = fn_out.c2[p];
                    foe = fn_oe.c2[p];
                end
                `PMX_CODE_4: begin
                    fo  = fn_out.c4[p];
                    foe = fn_oe.c4[p];
                end
                `PMX_CODE_8: begin
                    fo  = fn_out.c8[p];
                    foe = fn_oe.c8[p];
                end
                default: begin
                    fo  = fn_out.c0[p];
                    foe = fn_oe.c0[p];
                end
            endcase
        end
        assign pad_oe_d[p] = (kind == PMX_K_OUT)
                          || (kind == PMX_K_IO && foe);
        assign pad_o_d[p]  = drv & fo;
        assign fn_in_d.c0[p] = rcv && code == `PMX_CODE_0 && sync2_q[p];
        assign fn_in_d.c1[p] = rcv && code == `PMX_CODE_1 && sync2_q[p];
        assign fn_in_d.c2[p] = rcv && code == `PMX_CODE_2 && sync2_q[p];
        assign fn_in_d.c4[p] = rcv && code == `PMX_CODE_4 && sync2_q[p];
        assign fn_in_d.c8[p] = rcv && code == `PMX_CODE_8 && sync2_q[p];
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pad_oe_q <= '0;
            pad_o_q  <= '0;
            fn_in_q  <= '0;
        end else begin
            pad_oe_q <= pad_oe_d;
            pad_o_q  <= pad_o_d;
            fn_in_q  <= fn_in_d;
        end
    end

    assign avl_waitrequest = wait_q;
    assign avl_readdata    = rdata_q;
    assign pad_oe          = pad_oe_q;
    assign pad_o           = pad_o_q;
    assign fn_in           = fn_in_q;

    // ********************************************************
    // Checks
    // ********************************************************
    a_reset_clear: assert property (@(posedge sys_clk)
        sys_rst |=> (sel_q == '0 && pad_oe_q == '0))
        else $error("banks not cleared by reset");

    a_write_field: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (take && avl_req.write && avl_req.address == `PMX_OFS_BANK16
         && avl_req.byteenable == 4'h1)
        |=> (sel_q[2][7:0] == $past(avl_req.writedata[7:0])
             && sel_q[2][31:8] == $past(sel_q[2][31:8])
             && sel_q[1:0] == $past(sel_q[1:0])
             && sel_q[3] == $past(sel_q[3]))
        ##1 ((sel_q[2][3:0] == `PMX_CODE_8) -> pad_oe_q[16]))
        else $error("field write disturbed neighbours");

    a_input_undrv: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (sel_q[0][3:0] == `PMX_CODE_0) |=> !pad_oe_q[0])
        else $error("input pad driven");

    a_host_data: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (sel_q[0][11:8] == `PMX_CODE_2)
        |=> (pad_oe_q[2] == $past(fn_oe.c2[2])
             && pad_o_q[2] == $past(fn_out.c2[2])))
        else $error("host data not routed");

    a_clk_pad_out: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (sel_q[0][7:4] == `PMX_CODE_4) |=> pad_oe_q[1])
        else $error("rt output not driven");

    a_rt0_output: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (sel_q[1][31:28] == `PMX_CODE_8) |=> pad_oe_q[15])
        else $error("rt-unit-0 output not driven");

    a_no_code8: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (sel_q[1][3:0] == `PMX_CODE_8) |=> !pad_oe_q[8])
        else $error("reserved code drives pad");

    a_video_out: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (sel_q[2][31:28] == `PMX_CODE_1) |=> pad_oe_q[23])
        else $error("video display pad not driven");

    a_video_in8: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (sel_q[2][7:4] == `PMX_CODE_1) |=> !pad_oe_q[17])
        else $error("video capture pad driven");

    a_rt0_bit9: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (sel_q[2][3:0] == `PMX_CODE_8) |=> pad_oe_q[16])
        else $error("rt-unit-0 bit not driven");

    a_boot_input: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (sel_q[3][31:28] == `PMX_CODE_0) [*2]
        |=> (!pad_oe_q[31] && fn_in_q.c0[31] == $past(sync2_q[31])))
        else $error("boot strap pad not an input");

endmodule : pmx_pad_select

// ===== rtl/pmx_cfg.svh
`ifndef PMX_CFG_SVH
`define PMX_CFG_SVH

// ************************************************************
// Register map
// ************************************************************
`define PMX_ADDR_W      6
`define PMX_DATA_W      32
`define PMX_BE_W        4
`define PMX_NREG        4
`define PMX_NPAD        32
`define PMX_FIELD_W     4
`define PMX_FIELDS      8
`define PMX_OFS_BANK14  6'h0_0
`define PMX_OFS_BANK15  6'h0_4
`define PMX_OFS_BANK16  6'h0_8
`define PMX_OFS_BANK17  6'h0_C
`define PMX_RST_BANK    32'h0000_0000
`define PMX_RD_UNMAPPED 32'h0000_0000

// ************************************************************
// Selector codes
// ************************************************************
`define PMX_CODE_0      4'h0
`define PMX_CODE_1      4'h1
`define PMX_CODE_2      4'h2
`define PMX_CODE_4      4'h4
`define PMX_CODE_8      4'h8

// ************************************************************
// Bank and field indices
// ************************************************************
`define PMX_REG14       2'h0
`define PMX_REG15       2'h1
`define PMX_REG16       2'h2
`define PMX_REG17       2'h3
`define PMX_NIB_LO1     3'h1

`endif

// ===== rtl/pmx_pkg.sv
`include "pmx_cfg.svh"

package pmx_pkg;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [1:0] {
        PMX_K_NONE = 2'b00,
        PMX_K_IN   = 2'b01,
        PMX_K_OUT  = 2'b10,
        PMX_K_IO   = 2'b11
    } pmx_kind_e;

    typedef struct packed {
        logic                      read;
        logic                      write;
        logic [`PMX_ADDR_W-1:0]    address;
        logic [`PMX_DATA_W-1:0]    writedata;
        logic [`PMX_BE_W-1:0]      byteenable;
    } pmx_avl_req_s;

    typedef struct packed {
        logic [`PMX_NPAD-1:0] c8;
        logic [`PMX_NPAD-1:0] c4;
        logic [`PMX_NPAD-1:0] c2;
        logic [`PMX_NPAD-1:0] c1;
        logic [`PMX_NPAD-1:0] c0;
    } pmx_fn_s;

    typedef logic [`PMX_NREG-1:0][`PMX_DATA_W-1:0] pmx_bank_t;

endpackage : pmx_pkg

// ===== tb/pmx_pad_select_bench.sv
`include "pmx_cfg.svh"

module pmx_pad_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pmx_pkg::*;

    localparam logic [159:0] out_pat = {32'hA5A5_0F0F, 32'h5A5A_F0F0,
        32'h3333_CCCC, 32'hC3C3_3C3C, 32'h9696_6969};
    localparam logic [159:0] oe_pat  = {32'h0F0F_F0F0, 32'hFF00_00FF,
        32'h5555_AAAA, 32'hAAAA_5555, 32'h6699_9966};

    logic         sys_clk         = 1'b0;
    logic         sys_rst         = 1'b1;
    pmx_avl_req_s avl_req         = '0;
    logic         avl_waitrequest;
    logic [31:0]  avl_readdata;
    pmx_fn_s      fn_out          = '0;
    pmx_fn_s      fn_oe           = '0;
    pmx_fn_s      fn_in;
    logic [31:0]  pad_i           = 32'h3CA5_96E1;
    logic [31:0]  pad_o;
    logic [31:0]  pad_oe;
    int           num_errors      = 0;
    int           check_count     = 0;
    logic [3:0]   codes [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h9};

    always #2.5 sys_clk = ~sys_clk;

    pmx_pad_select i_pmx_pad_select (
        .sys_clk         (sys_clk),
        .sys_rst         (sys_rst),
        .avl_req         (avl_req),
        .avl_waitrequest (avl_waitrequest),
        .avl_readdata    (avl_readdata),
        .fn_out          (fn_out),
        .fn_oe           (fn_oe),
        .fn_in           (fn_in),
        .pad_i           (pad_i),
        .pad_o           (pad_o),
        .pad_oe          (pad_oe)
    );

    // ********************************************************
    // Tasks
    // ********************************************************
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : check

    task automatic bus(input logic wr, input logic [5:0] adr,
                       input logic [31:0] wd, input logic [3:0] be,
                       output logic [31:0] rd);
        pmx_avl_req_s r;
        int           n;
        r = '{read: !wr, write: wr, address: adr, writedata: wd,
              byteenable: be};
        n = 0;
        @(posedge sys_clk);
        avl_req <= r;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avl_waitrequest !== 1'b0 && n < 40);
        if (avl_waitrequest !== 1'b0) begin
            $display("[FAIL] waitrequest expected 0 seen %b", avl_waitrequest);
            num_errors++;
            report_and_stop();
        end else begin
            rd = avl_readdata;
            avl_req <= '0;
        end
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        logic [31:0] x;
        bus(1'b1, a, d, be, x);
    endtask : wr

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, 4'hF, x);
        check($sformatf("bank at %h", a), exp, x);
    endtask : rd_chk

    function automatic pmx_kind_e kind_of(int b, int f, logic [3:0] c);
        case (c)
            4'h0: return PMX_K_IN;
            4'h1: return (b == 3 || (b == 2 && f > 1)) ? PMX_K_OUT : PMX_K_IN;
            4'h2: return (b == 0 && f < 2) ? PMX_K_IN : PMX_K_IO;
            4'h4: return (b == 0 && f < 2) ? PMX_K_OUT : PMX_K_IO;
            4'h8: begin
                if (b == 0) return (f < 2) ? PMX_K_IO : PMX_K_NONE;
                if (b == 1) return (f < 2) ? PMX_K_NONE : PMX_K_OUT;
                return (b == 2 && f == 0) ? PMX_K_OUT : PMX_K_IO;
            end
            default: return PMX_K_NONE;
        endcase
    endfunction : kind_of

    task automatic check_pads(input logic [3:0] c);
        pmx_kind_e   k;
        int          idx;
        int          ii;
        logic [31:0] e_oe, e_o, m_o, e_in, m_in;
        idx = (c == 4'h0) ? 0 : (c == 4'h1) ? 1 : (c == 4'h2) ? 2 :
              (c == 4'h4) ? 3 : (c == 4'h8) ? 4 : -1;
        ii = (idx < 0) ? 0 : idx;
        e_oe = '0;
        m_o = '1;
        e_in = '0;
        m_in = '1;
        for (int p = 0; p < 32; p++) begin
            k = kind_of(p / 8, p % 8, c);
            if (k == PMX_K_OUT) e_oe[p] = 1'b1;
            if (k == PMX_K_IN) e_in[p] = pad_i[p];
            if (k == PMX_K_IO) begin
                e_oe[p] = oe_pat[ii*32+p];
                m_o[p] = e_oe[p];
                m_in[p] = 1'b0;
            end
        end
        e_o = e_oe & out_pat[ii*32+:32];
        check("pad_oe", e_oe, pad_oe);
        check("pad_o", e_o, pad_o & m_o);
        for (int j = 0; j < 5; j++) begin
            check($sformatf("fn_in %0d", j), (j == idx) ? e_in : '0,
                  fn_in[j*32+:32] & ((j == idx) ? m_in : '1));
        end
    endtask : check_pads

    // ********************************************************
    // Sequence
    // ********************************************************
    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        fn_out <= out_pat;
        fn_oe <= oe_pat;
        repeat (4) @(posedge sys_clk);
        #1;
        check_pads(4'h0);
        for (int b = 0; b < 4; b++) rd_chk(6'(b * 4), '0);
        for (int i = 0; i < 7; i++) begin
            for (int b = 0; b < 4; b++) wr(6'(b * 4), {8{codes[i]}}, 4'hF);
            for (int b = 0; b < 4; b++) rd_chk(6'(b * 4), {8{codes[i]}});
            pad_i <= ~pad_i;
            repeat (4) @(posedge sys_clk);
            #1;
            check_pads(codes[i]);
        end
        wr(6'h08, 32'hFFFF_FF18, 4'h1);
        #1;
        check("pad_oe before", 32'h0000_0000, pad_oe);
        @(posedge sys_clk);
        #1;
        check("pad_oe after", 32'h0001_0000, pad_oe);
        check("pad_o after", {15'h0, out_pat[144], 16'h0}, pad_o);
        rd_chk(6'h08, 32'h9999_9918);
        rd_chk(6'h04, 32'h9999_9999);
        wr(6'h10, 32'hFFFF_FFFF, 4'hF);
        rd_chk(6'h10, 32'h0000_0000);
        rd_chk(6'h09, 32'h0000_0000);
        rd_chk(6'h0C, 32'h9999_9999);
        report_and_stop();
    end
endmodule : pmx_pad_select_bench
